// ### rtl/pbcd_defines.vh
// constants for the port b/c/d alternate-function override block
// Behaviour
// - spi master forces master-data-in pin input
// - spi slave: master-data-in direction from register
// - spi slave forces slave-data-in pin input
// - spi master: slave-data-in direction from register
// - spi slave forces serial clock pin input
// - spi master: clock dir register, value spi
// - spi slave forces select pin input
// - slave active only while select held low
// - master: select direction register, value untouched
// - forced input keeps port-bit pull-up, global disable
// - data pins carry master/slave in/out correctly
// - legacy mode: no timer1 compare c on bit7
// - legacy mode: port c output only
// - port c bits carry address 15..8
// - port c override per-pin mask threshold
// - memory override: output, no pull-up, address
// - legacy mode reads address mask as zero
// - legacy mode: usart1 unavailable
// - usart1 clock direction from its direction bit
// - usart1 clock pin only in synchronous mode
`ifndef PBCD_DEFINES_VH
`define PBCD_DEFINES_VH
`define PBCD_MISO_BIT 3
`define PBCD_MOSI_BIT 2
`define PBCD_SCK_BIT 1
`define PBCD_SEL_BIT 0
`define PBCD_CMP_LSB 4
`define PBCD_XCK_BIT 5
`define PBCD_T1_BIT 6
`define PBCD_T2_BIT 7
`define PBCD_XMM_W 3
`define PBCD_XMM_ZERO 3'h0
`define PBCD_RST_BYTE 8'h00
`endif

// ### rtl/pbcd_sync2.v
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pbcd_sync2 #(
	parameter W = 8
) (
	input wire mclk,
	input wire rst_b,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// first stage read only by the second stage
	always @(posedge mclk) begin
		if (!rst_b) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule // pbcd_sync2

// ### rtl/pbcd_override.v
// port b/c/d alternate-function override: direction, pull-up and value per pin
`timescale 1ns/1ps
`include "pbcd_defines.vh"
module pbcd_override (
	input wire mclk,
	input wire rst_b,
	// port registers (same clock domain)
	input wire [7:0] portb_dir,
	input wire [7:0] portb_out,
	input wire [7:0] portc_dir,
	input wire [7:0] portc_out,
	input wire [7:0] portd_dir,
	input wire [7:0] portd_out,
	input wire global_pullup_disable,
	input wire legacy_mode,
	// serial peripheral interface
	input wire serial_if_enable,
	input wire serial_if_master_select,
	input wire spi_master_out,
	input wire spi_slave_out,
	input wire spi_clock_out,
	output reg spi_master_in,
	output reg spi_slave_in,
	output reg spi_clock_in,
	output reg spi_select_n_in,
	output reg spi_slave_active,
	// timer compare outputs and their enables
	input wire timer0_compare_out,
	input wire timer0_compare_en,
	input wire timer1_compare_out_a,
	input wire timer1_compare_a_en,
	input wire timer1_compare_out_b,
	input wire timer1_compare_b_en,
	input wire timer1_compare_out_c,
	input wire timer1_compare_c_en,
	input wire timer2_compare_out,
	input wire timer2_compare_en,
	// external memory interface
	input wire ext_mem_enable,
	input wire [`PBCD_XMM_W-1:0] ext_addr_mask,
	input wire [7:0] ext_addr_high,
	// usart1 clock, usart1 availability and timer count inputs
	input wire usart1_sync_mode,
	input wire usart1_ext_clock_out,
	output reg usart1_ext_clock_in,
	output reg usart1_available,
	output reg timer1_count_input,
	output reg timer2_count_input,
	// pins
	input wire [7:0] portb_pin_in,
	input wire [7:0] portc_pin_in,
	input wire [7:0] portd_pin_in,
	output reg [7:0] portb_pin_out,
	output reg [7:0] portb_pin_oe,
	output reg [7:0] portb_pullup,
	output reg [7:0] portc_pin_out,
	output reg [7:0] portc_pin_oe,
	output reg [7:0] portc_pullup,
	output reg [7:0] portd_pin_out,
	output reg [7:0] portd_pin_oe,
	output reg [7:0] portd_pullup,
	output reg [7:0] portb_sync_in,
	output reg [7:0] portc_sync_in,
	output reg [7:0] portd_sync_in
);
	wire [7:0] pb_s;
	wire [7:0] pc_s;
	wire [7:0] pd_s;
	wire spi_mst;
	wire spi_slv;
	wire [`PBCD_XMM_W-1:0] mask_eff;
	wire [7:0] mem_ovr;
	reg [7:0] b_dir_d;
	reg [7:0] b_val_d;
	reg [7:0] b_pu_d;
	reg [7:0] c_dir_d;
	reg [7:0] c_val_d;
	reg [7:0] c_pu_d;
	reg [7:0] d_dir_d;
	reg [7:0] d_val_d;
	reg [7:0] d_pu_d;
	reg b7_en;
	reg b7_val;
	genvar gi;

	// pins cross into mclk before any logic looks at them
	pbcd_sync2 #(.W(8)) u_sync_b (.mclk(mclk), .rst_b(rst_b), .d(portb_pin_in), .q(pb_s));
	pbcd_sync2 #(.W(8)) u_sync_c (.mclk(mclk), .rst_b(rst_b), .d(portc_pin_in), .q(pc_s));
	pbcd_sync2 #(.W(8)) u_sync_d (.mclk(mclk), .rst_b(rst_b), .d(portd_pin_in), .q(pd_s));

	assign spi_mst = serial_if_enable & serial_if_master_select;
	assign spi_slv = serial_if_enable & ~serial_if_master_select;

	// legacy mode hides the mask, releasing the whole byte
	assign mask_eff = legacy_mode ? `PBCD_XMM_ZERO : ext_addr_mask;

	// per-pin threshold: bit7 needs mask<1, bits 1 and 0 need mask<7
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_mem
			localparam integer THR = (gi < 2) ? 7 : (8 - gi);
			assign mem_ovr[gi] = ext_mem_enable &
				({1'b0, mask_eff} < THR[`PBCD_XMM_W:0]);
		end
	endgenerate

	// bit7 source: timer1 channel c does not exist in legacy mode
	always @* begin
		b7_en = timer2_compare_en;
		b7_val = timer2_compare_out;
		if (!legacy_mode && timer1_compare_c_en) begin
			b7_en = 1'b1;
			b7_val = timer1_compare_out_c;
		end
		if (legacy_mode) begin
			b7_en = timer2_compare_en;
			b7_val = timer2_compare_out;
		end
	end

	// port b: compare values on the top nibble, spi on the bottom
	always @* begin
		b_dir_d = portb_dir;
		b_val_d = portb_out;
		// only the value is replaced; direction stays with software
		if (timer0_compare_en) b_val_d[`PBCD_CMP_LSB] = timer0_compare_out;
		if (timer1_compare_a_en) b_val_d[5] = timer1_compare_out_a;
		if (timer1_compare_b_en) b_val_d[6] = timer1_compare_out_b;
		if (b7_en) b_val_d[7] = b7_val;
		if (spi_mst) begin
			b_dir_d[`PBCD_MISO_BIT] = 1'b0;
			b_val_d[`PBCD_MOSI_BIT] = spi_master_out;
			b_val_d[`PBCD_SCK_BIT] = spi_clock_out;
			// select pin keeps register direction and value
		end
		if (spi_slv) begin
			b_dir_d[`PBCD_MOSI_BIT] = 1'b0;
			b_dir_d[`PBCD_SCK_BIT] = 1'b0;
			b_dir_d[`PBCD_SEL_BIT] = 1'b0;
			b_val_d[`PBCD_MISO_BIT] = spi_slave_out;
		end
		// pull-up from the port bit on input pins, forced ones included
		b_pu_d = ~b_dir_d & portb_out & {8{~global_pullup_disable}};
	end

	// port c: high address byte or plain port
	always @* begin
		c_dir_d = portc_dir;
		c_val_d = portc_out;
		c_pu_d = ~portc_dir & portc_out & {8{~global_pullup_disable}};
		if (legacy_mode) begin
			c_dir_d = 8'hff;
			c_pu_d = `PBCD_RST_BYTE;
		end
		c_dir_d = c_dir_d | mem_ovr;
		c_pu_d = c_pu_d & ~mem_ovr;
		c_val_d = (c_val_d & ~mem_ovr) | (ext_addr_high & mem_ovr);
	end

	// port d: usart1 clock is the only value override here
	always @* begin
		d_dir_d = portd_dir;
		d_val_d = portd_out;
		d_pu_d = ~portd_dir & portd_out & {8{~global_pullup_disable}};
		if (usart1_sync_mode && !legacy_mode) begin
			d_val_d[`PBCD_XCK_BIT] = usart1_ext_clock_out;
		end
	end

	// registered pin drive; data outputs come from flops
	always @(posedge mclk) begin
		if (!rst_b) begin
			portb_pin_out <= `PBCD_RST_BYTE;
			portb_pin_oe <= `PBCD_RST_BYTE;
			portb_pullup <= `PBCD_RST_BYTE;
			portc_pin_out <= `PBCD_RST_BYTE;
			portc_pin_oe <= `PBCD_RST_BYTE;
			portc_pullup <= `PBCD_RST_BYTE;
			portd_pin_out <= `PBCD_RST_BYTE;
			portd_pin_oe <= `PBCD_RST_BYTE;
			portd_pullup <= `PBCD_RST_BYTE;
		end else begin
			portb_pin_out <= b_val_d;
			portb_pin_oe <= b_dir_d;
			portb_pullup <= b_pu_d;
			portc_pin_out <= c_val_d;
			portc_pin_oe <= c_dir_d;
			portc_pullup <= c_pu_d;
			portd_pin_out <= d_val_d;
			portd_pin_oe <= d_dir_d;
			portd_pullup <= d_pu_d;
		end
	end

	// registered inputs to the peripherals
	always @(posedge mclk) begin
		if (!rst_b) begin
			spi_master_in <= 1'b0;
			spi_slave_in <= 1'b0;
			spi_clock_in <= 1'b0;
			spi_select_n_in <= 1'b1;
			spi_slave_active <= 1'b0;
			usart1_ext_clock_in <= 1'b0;
			usart1_available <= 1'b0;
			timer1_count_input <= 1'b0;
			timer2_count_input <= 1'b0;
			portb_sync_in <= `PBCD_RST_BYTE;
			portc_sync_in <= `PBCD_RST_BYTE;
			portd_sync_in <= `PBCD_RST_BYTE;
		end else begin
			spi_master_in <= pb_s[`PBCD_MISO_BIT];
			spi_slave_in <= pb_s[`PBCD_MOSI_BIT];
			spi_clock_in <= pb_s[`PBCD_SCK_BIT];
			spi_select_n_in <= pb_s[`PBCD_SEL_BIT];
			// slave wakes only while the far master holds select low
			spi_slave_active <= spi_slv & ~pb_s[`PBCD_SEL_BIT];
			usart1_ext_clock_in <= pd_s[`PBCD_XCK_BIT] & usart1_sync_mode & ~legacy_mode;
			usart1_available <= ~legacy_mode;
			timer1_count_input <= pd_s[`PBCD_T1_BIT];
			timer2_count_input <= pd_s[`PBCD_T2_BIT];
			portb_sync_in <= pb_s;
			portc_sync_in <= pc_s;
			portd_sync_in <= pd_s;
		end
	end
endmodule // pbcd_override

// ### bench/pbcd_override_sva.sv
// assertions on the port b/c/d override block
`timescale 1ns/1ps
module pbcd_override_sva (
	input wire mclk,
	input wire rst_b,
	input wire [7:0] portb_dir,
	input wire [7:0] portb_out,
	input wire global_pullup_disable,
	input wire legacy_mode,
	input wire serial_if_enable,
	input wire serial_if_master_select,
	input wire timer2_compare_out,
	input wire timer2_compare_en,
	input wire ext_mem_enable,
	input wire [2:0] ext_addr_mask,
	input wire [7:0] portb_pin_out,
	input wire [7:0] portb_pin_oe,
	input wire [7:0] portb_pullup,
	input wire [7:0] portc_pin_oe,
	input wire [7:0] portc_pullup
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// outputs are only trusted two edges after reset, as the first one still shows reset values
	sequence s_run; $past(rst_b) && $past(rst_b, 2); endsequence
	sequence s_mst; s_run ##0 $past(serial_if_enable && serial_if_master_select); endsequence
	sequence s_slv; s_run ##0 $past(serial_if_enable && !serial_if_master_select); endsequence
	a_miso_in: assert property (s_mst |-> !portb_pin_oe[3])
		else $error("miso oe");
	a_miso_dir: assert property (s_slv |-> portb_pin_oe[3] == $past(portb_dir[3]))
		else $error("miso dir");
	a_slave_inputs: assert property (s_slv |-> portb_pin_oe[2:0] == 3'h0)
		else $error("slave oe");
	a_master_dirs: assert property (s_mst |-> portb_pin_oe[2:0] == $past(portb_dir[2:0]))
		else $error("master oe");
	a_forced_pullup: assert property (s_slv |->
		portb_pullup[2:0] == $past(portb_out[2:0] & {3{!global_pullup_disable}})) else $error("pullup");
	a_legacy_bit7: assert property (s_run ##0 $past(legacy_mode && timer2_compare_en) |->
		portb_pin_out[7] == $past(timer2_compare_out)) else $error("bit7");
	a_legacy_portc: assert property (s_run ##0 $past(legacy_mode) |-> portc_pin_oe == 8'hff)
		else $error("portc oe");
	a_mem_pullup: assert property (s_run ##0
		$past(ext_mem_enable && (legacy_mode || ext_addr_mask == 3'h0)) |-> portc_pullup == 8'h00)
		else $error("portc pullup");
endmodule // pbcd_override_sva
bind pbcd_override pbcd_override_sva u_sva (.*);

// ### bench/pbcd_spi_peer.sv
// far-side spi peer: resolves the port b wires from all drivers
`timescale 1ns/1ps
module pbcd_spi_peer (
	input wire [7:0] portb_pin_out,
	input wire [7:0] portb_pin_oe,
	input wire [7:0] portb_pullup,
	input wire peer_sel_n,
	input wire peer_data,
	output wire [7:0] portb_pin_in
);
	// peer drives select and both data pins only where the device lets go
	wire [7:0] peer_en = 8'h0d & ~portb_pin_oe;
	wire [7:0] peer_val = {4'h0, peer_data, peer_data, 1'b0, peer_sel_n};
	// floating wires read high where the pull-up is on, else the inverse of portb_pin_out, never a stale level
	assign portb_pin_in = (portb_pin_oe & portb_pin_out) | (peer_en & peer_val)
		| (~portb_pin_oe & ~peer_en & (portb_pullup | ~portb_pin_out));
endmodule // pbcd_spi_peer

// ### bench/testbench.sv
// self-checking bench for the port b/c/d override block
`timescale 1ns/1ps
module testbench;
	logic mclk, rst_b, global_pullup_disable, legacy_mode, serial_if_enable, serial_if_master_select;
	logic spi_master_out, spi_slave_out, spi_clock_out, spi_master_in, spi_slave_in, spi_clock_in;
	logic spi_select_n_in, spi_slave_active, timer0_compare_out, timer0_compare_en;
	logic timer1_compare_out_a, timer1_compare_a_en, timer1_compare_out_b, timer1_compare_b_en;
	logic timer1_compare_out_c, timer1_compare_c_en, timer2_compare_out, timer2_compare_en;
	logic ext_mem_enable, usart1_sync_mode, usart1_ext_clock_out, usart1_ext_clock_in;
	logic usart1_available, timer1_count_input, timer2_count_input, peer_sel_n, peer_data;
	logic [2:0] ext_addr_mask;
	logic [7:0] portb_dir, portb_out, portc_dir, portc_out, portd_dir, portd_out, ext_addr_high;
	logic [7:0] portb_pin_in, portc_pin_in, portd_pin_in, portb_pin_out, portb_pin_oe, portb_pullup;
	logic [7:0] portc_pin_out, portc_pin_oe, portc_pullup, portd_pin_out, portd_pin_oe, portd_pullup;
	logic [7:0] portb_sync_in, portc_sync_in, portd_sync_in;
	int n_mismatch = 0;
	int n_checks = 0;
	pbcd_override u_dut (.*);
	pbcd_spi_peer u_peer (.*);
	// port c reads back what it drives
	assign portc_pin_in = portc_pin_out;
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic give_verdict;
		if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_master;
		@(posedge mclk);
		{serial_if_enable, serial_if_master_select, spi_master_out, peer_data} <= 4'hf;
		{portb_dir, portb_out} <= 16'h0f0f;
		settle(5);
		chk("oe mst", 8'h07, portb_pin_oe & 8'h0f);
		chk("out mst", 8'h05, portb_pin_out & 8'h07);
		chk("pu mst", 8'h08, portb_pullup & 8'h08);
		chk("in mst", 8'h01, {7'h0, spi_master_in});
		@(posedge mclk);
		global_pullup_disable <= 1'b1;
		settle(2);
		chk("pu off", 8'h00, portb_pullup & 8'h08);
	endtask
	task automatic t_slave;
		@(posedge mclk);
		{serial_if_master_select, global_pullup_disable} <= 2'h0;
		settle(5);
		chk("oe slv", 8'h08, portb_pin_oe & 8'h0f);
		chk("out slv", 8'h00, portb_pin_out & 8'h08);
		chk("pu slv", 8'h07, portb_pullup & 8'h07);
		chk("idle slv", 8'h00, {7'h0, spi_slave_active});
		@(posedge mclk);
		peer_sel_n <= 1'b0;
		settle(5);
		chk("act slv", 8'h03, {6'h0, spi_slave_active, spi_slave_in});
		chk("sel clk slv", 8'h02, {6'h0, spi_clock_in, spi_select_n_in});
	endtask
	task automatic t_cmp;
		@(posedge mclk);
		portb_dir <= 8'hf0;
		{timer0_compare_out, timer1_compare_out_b, timer1_compare_out_c} <= 3'h7;
		{timer0_compare_en, timer1_compare_a_en, timer1_compare_b_en} <= 3'h7;
		{timer1_compare_c_en, timer2_compare_en} <= 2'h3;
		settle(2);
		chk("cmp", 8'hd0, portb_pin_out & 8'hf0);
		@(posedge mclk);
		legacy_mode <= 1'b1;
		settle(2);
		chk("cmp lgc", 8'h50, portb_pin_out & 8'hf0);
		chk("usart lgc", 8'h00, {7'h0, usart1_available});
	endtask
	task automatic t_portc;
		logic [7:0] m;
		@(posedge mclk);
		{legacy_mode, ext_mem_enable} <= 2'h1;
		{ext_addr_high, portc_out} <= 16'ha5ff;
		for (int x = 0; x < 8; x++) begin
			@(posedge mclk);
			ext_addr_mask <= x[2:0];
			settle(2);
			for (int n = 0; n < 8; n++) m[n] = x < ((n < 2) ? 7 : 8 - n);
			chk("pc oe", m, portc_pin_oe);
			chk("pc out", (m & 8'ha5) | ~m, portc_pin_out);
			chk("pc pu", ~m, portc_pullup);
		end
		@(posedge mclk);
		legacy_mode <= 1'b1;
		settle(2);
		chk("pc lgc", 8'ha5, portc_pin_out & portc_pin_oe);
	endtask
	task automatic t_portd;
		@(posedge mclk);
		{legacy_mode, usart1_sync_mode, usart1_ext_clock_out} <= 3'h3;
		{portd_pin_in, portd_dir} <= 16'h8020;
		settle(5);
		chk("counts", 8'h01, {6'h0, timer1_count_input, timer2_count_input});
		chk("pd sync", 8'h80, portd_sync_in);
		chk("pd oe", 8'h20, portd_pin_oe);
		chk("pd out", 8'h20, portd_pin_out);
		chk("usart", 8'h01, {7'h0, usart1_available});
		@(posedge mclk);
		{usart1_sync_mode, portd_dir} <= 9'h000;
		settle(2);
		chk("pd idle", 8'h00, portd_pin_out | portd_pin_oe);
	endtask
	initial begin
		{legacy_mode, global_pullup_disable, serial_if_enable, serial_if_master_select, spi_master_out,
			spi_slave_out, spi_clock_out, timer0_compare_out, timer0_compare_en, timer1_compare_out_a,
			timer1_compare_a_en, timer1_compare_out_b, timer1_compare_b_en, timer1_compare_out_c,
			timer1_compare_c_en, timer2_compare_out, timer2_compare_en, ext_mem_enable,
			usart1_sync_mode, usart1_ext_clock_out, peer_data, ext_addr_mask} = '0;
		{portb_dir, portb_out, portc_dir, portc_out, portd_dir, portd_out, ext_addr_high} = '0;
		portd_pin_in = 8'h00;
		peer_sel_n = 1'b1;
		rst_b = 1'b0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		settle(2);
		t_master;
		t_slave;
		t_cmp;
		t_portc;
		t_portd;
		give_verdict;
	end
	// watchdog, far beyond the under a hundred cycles the tests need
	initial begin
		#100000;
		n_mismatch++;
		give_verdict;
	end
endmodule // testbench
